// >>> hfh_consts.vh
// register map, field layout and line constants for the hdlc port
`ifndef HFH_CONSTS_VH
`define HFH_CONSTS_VH
// register offsets within one port
`define HFH_OFF_RX_MAP     9'h010
`define HFH_OFF_RX_SUP     9'h011
`define HFH_OFF_RX_WM      9'h087
`define HFH_OFF_RX_LAT     9'h094
`define HFH_OFF_RX_MASK    9'h0a4
`define HFH_OFF_RX_LIVE    9'h0b4
`define HFH_OFF_RX_AVAIL   9'h0b5
`define HFH_OFF_RX_DATA    9'h0b6
`define HFH_OFF_TX_MISC    9'h110
`define HFH_OFF_TX_SUP     9'h111
`define HFH_OFF_TX_MAP     9'h113
`define HFH_OFF_TX_WM      9'h187
`define HFH_OFF_TX_LAT     9'h191
`define HFH_OFF_TX_MASK    9'h1a1
`define HFH_OFF_TX_LIVE    9'h1b1
`define HFH_OFF_TX_AVAIL   9'h1b3
`define HFH_OFF_TX_DATA    9'h1b4
// map control fields
`define HFH_MAP_SLOT       4:0
`define HFH_MAP_MODE       6:5
`define HFH_MODE_SLOT      2'h0
`define HFH_MODE_FDL       2'h1
`define HFH_MODE_SA        2'h2
// watermark field
`define HFH_WM_LVL         5:0
// live status bits
`define HFH_LIVE_NEMPTY    0
`define HFH_LIVE_WM        1
// receive latched bits
`define HFH_RX_LAT_WM      1
`define HFH_RX_LAT_EOP     2
`define HFH_RX_LAT_ABT     3
`define HFH_RX_LAT_CRC     4
`define HFH_RX_LAT_OVR     5
// transmit latched bits
`define HFH_TX_LAT_WM      1
`define HFH_TX_LAT_UDR     2
`define HFH_TX_LAT_EOP     3
`define HFH_TX_LAT_OVF     4
// misc control and count fields
`define HFH_TX_MISC_EOM    0
`define HFH_AVAIL_CONT     7
// reset values
`define HFH_RST_REG        8'h00
// line coding
`define HFH_FLAG           8'h7e
`define HFH_ABORT          8'hff
`define HFH_CRC_INIT       16'hffff
`define HFH_CRC_POLY       16'h8408
`define HFH_CRC_GOOD       16'hf0b8
`endif

// >>> hfh_hdlc_port.v
// one hdlc port: fifos, host registers, framing engines, interrupt
//
// Summary of operation
// - rx high watermark live flag set while rx fill level exceeds watermark
// - tx low watermark live flag set while tx fill level is below watermark
// - tx low watermark event, when unmasked, drives the interrupt low
// - rx overrun drops current packet, empties rx fifo, latches overrun bit 5
// - bytes-available low 7 bits give readable rx bytes, 0 to 64
// - bytes-available count stops at the end of the oldest message
// - bytes-available msb is 1 when the message has not yet ended
// - latched bits stay set until cleared, set again only on new event
// - status write clears bits written one, live bits untouched
// - each latched event has its own interrupt mask bit
// - unmasked latched event drives interrupt output low
// - interrupt released when host reads the status holding the event
// - tx buffer-available gives free bytes in the tx fifo
// - tx buffer-available is live but held stable through the read
// - watermarks come from the rx and tx fifo control registers
// - port n registers sit at port one offset plus (n-1) times 200h
// - controller maps onto one slot, the fdl or sa bits
// - bit-suppress register removes marked bit positions from the path in slot and sa modes, not in fdl mode
// - separate 64-byte fifo for transmit and receive
// - flags, aborts, crc, zero stuffing and byte alignment in hardware
`timescale 1ns/10ps
`default_nettype none
`include "hfh_consts.vh"
module hfh_hdlc_port #(
    parameter PORT_NUM = 1,
    parameter FIFO_AW  = 6
) (
    // clock and reset
    input  wire        i_clk,
    input  wire        i_rst,
    // host register port
    input  wire [12:0] i_addr,
    input  wire [7:0]  i_wdata,
    input  wire        i_wr,
    input  wire        i_rd,
    output reg  [7:0]  o_rdata,
    // receive line side
    input  wire        i_rx_bit_en,
    input  wire        i_rx_bit,
    input  wire [4:0]  i_rx_slot,
    input  wire [2:0]  i_rx_bitpos,
    input  wire        i_rx_fdl,
    input  wire        i_rx_sa,
    // transmit line side
    input  wire        i_tx_bit_req,
    input  wire [4:0]  i_tx_slot,
    input  wire [2:0]  i_tx_bitpos,
    input  wire        i_tx_fdl,
    input  wire        i_tx_sa,
    output reg         o_tx_bit,
    output reg         o_tx_bit_valid,
    // interrupt
    output reg         o_interrupt_out_n
);

    localparam DEPTH = 1 << FIFO_AW;
    localparam [31:0] PORT_M1 = PORT_NUM - 1;
    localparam [3:0] PORT_IDX = PORT_M1[3:0];
    localparam [FIFO_AW:0] FULL = {1'b1, {FIFO_AW{1'b0}}};
    localparam [1:0] T_IDLE = 2'h0;
    localparam [1:0] T_DATA = 2'h1;
    localparam [1:0] T_FCS  = 2'h2;
    localparam [1:0] T_ABRT = 2'h3;

    // slot, fdl or sa selection with bit suppression
    function slot_sel;
        input [7:0] ctl;
        input [7:0] sup;
        input [4:0] slot;
        input [2:0] pos;
        input       fdl;
        input       sa;
        begin
            case (ctl[`HFH_MAP_MODE])
                `HFH_MODE_SLOT: slot_sel = (slot == ctl[`HFH_MAP_SLOT])
                                           && !sup[pos];
                `HFH_MODE_FDL:  slot_sel = fdl;
                `HFH_MODE_SA:   slot_sel = sa && !sup[pos];
                default:        slot_sel = 1'b0;
            endcase
        end
    endfunction

    // crc-16 over one byte, lsb first
    function [15:0] crc_byte;
        input [15:0] crc;
        input [7:0]  data;
        integer k;
        reg [15:0] c;
        begin
            c = crc;
            for (k = 0; k < 8; k = k + 1) begin
                c = {1'b0, c[15:1]} ^ ((c[0] ^ data[k]) ? `HFH_CRC_POLY
                                                        : 16'h0000);
            end
            crc_byte = c;
        end
    endfunction

    // registers
    reg [7:0]         rx_map_r, rx_sup_r, rx_wm_r, rx_mask_r, rx_lat_r;
    reg [7:0]         tx_misc_r, tx_sup_r, tx_map_r, tx_wm_r;
    reg [7:0]         tx_mask_r, tx_lat_r;
    reg [7:0]         rx_pend_r, tx_pend_r;
    reg               rx_hwm_r, tx_lwm_r;
    // receive fifo
    reg [7:0]         rx_mem [0:DEPTH-1];
    reg [DEPTH-1:0]   rx_mark_r;
    reg [FIFO_AW-1:0] rx_rd_r, rx_wr_r;
    reg [FIFO_AW:0]   rx_cnt_r;
    reg               rx_drop_r;
    // transmit fifo
    reg [8:0]         tx_mem [0:DEPTH-1];
    reg [FIFO_AW-1:0] tx_rd_r, tx_wr_r;
    reg [FIFO_AW:0]   tx_cnt_r;
    // receive engine
    reg [2:0]         rx_ones_r, rx_bits_r;
    reg [7:0]         rx_sh_r, rx_h0_r, rx_h1_r;
    reg [1:0]         rx_held_r;
    reg               rx_infr_r, rx_any_r;
    reg [15:0]        rx_crc_r;
    reg               rx_push_r, rx_end_r, rx_start_r;
    reg [7:0]         rx_pbyte_r;
    reg               rx_ok_r, rx_bad_r, rx_abt_r;
    // transmit engine
    reg [1:0]         tx_st_r;
    reg [15:0]        tx_sh_r, tx_crc_r;
    reg [4:0]         tx_left_r;
    reg [2:0]         tx_ones_r;
    reg               tx_last_r;

    // host decode
    wire       hit    = (i_addr[12:9] == PORT_IDX);
    wire [8:0] off    = i_addr[8:0];
    wire       wr_hit = i_wr && hit;
    wire       rd_hit = i_rd && hit;

    wire rx_pop  = rd_hit && (off == `HFH_OFF_RX_DATA)
                   && (rx_cnt_r != 0);
    wire tx_wrt  = wr_hit && (off == `HFH_OFF_TX_DATA);
    wire tx_push = tx_wrt && (tx_cnt_r != FULL);
    wire rx_over = rx_push_r && !rx_drop_r && (rx_cnt_r == FULL);
    wire rx_put  = rx_push_r && !rx_drop_r && (rx_cnt_r != FULL);

    wire rx_take = i_rx_bit_en && slot_sel(rx_map_r, rx_sup_r, i_rx_slot,
                   i_rx_bitpos, i_rx_fdl, i_rx_sa);
    wire tx_take = i_tx_bit_req && slot_sel(tx_map_r, tx_sup_r, i_tx_slot,
                   i_tx_bitpos, i_tx_fdl, i_tx_sa);
    wire tx_stuff = (tx_st_r == T_DATA || tx_st_r == T_FCS)
                    && (tx_ones_r == 3'd5);
    wire tx_nxt   = tx_stuff ? 1'b0 : tx_sh_r[0];
    wire tx_pop   = tx_take && !tx_stuff && (tx_left_r == 5'd1)
                    && (tx_cnt_r != 0)
                    && (tx_st_r == T_IDLE
                        || (tx_st_r == T_DATA && !tx_last_r));
    wire tx_udr   = tx_take && !tx_stuff && (tx_left_r == 5'd1)
                    && tx_st_r == T_DATA && !tx_last_r && (tx_cnt_r == 0);
    wire tx_eop   = tx_take && !tx_stuff && (tx_left_r == 5'd1)
                    && tx_st_r == T_DATA && tx_last_r;
    wire [8:0] tx_head = tx_mem[tx_rd_r];

    // live watermark flags
    wire rx_hwm_nxt = rx_cnt_r > {1'b0, rx_wm_r[`HFH_WM_LVL]};
    wire tx_lwm_nxt = tx_cnt_r < {1'b0, tx_wm_r[`HFH_WM_LVL]};

    // latched event sources
    wire [7:0] rx_set = {2'b00,
                         rx_over,
                         rx_bad_r && !rx_drop_r,
                         rx_abt_r && !rx_drop_r,
                         rx_ok_r && !rx_drop_r,
                         rx_hwm_nxt && !rx_hwm_r,
                         1'b0};
    wire [7:0] tx_set = {3'b000,
                         tx_wrt && (tx_cnt_r == FULL),
                         tx_eop,
                         tx_udr,
                         tx_lwm_nxt && !tx_lwm_r,
                         1'b0};

    // bytes available up to the oldest message end
    reg [FIFO_AW:0]   avail;
    reg               found;
    reg [FIFO_AW-1:0] idx;
    integer i;
    always @* begin
        avail = {(FIFO_AW+1){1'b0}};
        found = 1'b0;
        idx   = {FIFO_AW{1'b0}};
        for (i = 0; i < DEPTH; i = i + 1) begin
            idx = rx_rd_r + i[FIFO_AW-1:0];
            if (!found && (i < rx_cnt_r)) begin
                avail = avail + 1'b1;
                found = rx_mark_r[idx];
            end
        end
    end
    wire rx_cont = (avail != 0) && !found;

    // control registers and latched status
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rx_map_r  <= `HFH_RST_REG;
            rx_sup_r  <= `HFH_RST_REG;
            rx_wm_r   <= `HFH_RST_REG;
            rx_mask_r <= `HFH_RST_REG;
            rx_lat_r  <= `HFH_RST_REG;
            rx_pend_r <= `HFH_RST_REG;
            tx_misc_r <= `HFH_RST_REG;
            tx_sup_r  <= `HFH_RST_REG;
            tx_map_r  <= `HFH_RST_REG;
            tx_wm_r   <= `HFH_RST_REG;
            tx_mask_r <= `HFH_RST_REG;
            tx_lat_r  <= `HFH_RST_REG;
            tx_pend_r <= `HFH_RST_REG;
            rx_hwm_r  <= 1'b0;
            tx_lwm_r  <= 1'b0;
        end else begin
            rx_hwm_r <= rx_hwm_nxt;
            tx_lwm_r <= tx_lwm_nxt;
            if (wr_hit && off == `HFH_OFF_RX_MAP)  rx_map_r  <= i_wdata;
            if (wr_hit && off == `HFH_OFF_RX_SUP)  rx_sup_r  <= i_wdata;
            if (wr_hit && off == `HFH_OFF_RX_WM)   rx_wm_r   <= i_wdata;
            if (wr_hit && off == `HFH_OFF_RX_MASK) rx_mask_r <= i_wdata;
            if (wr_hit && off == `HFH_OFF_TX_SUP)  tx_sup_r  <= i_wdata;
            if (wr_hit && off == `HFH_OFF_TX_MAP)  tx_map_r  <= i_wdata;
            if (wr_hit && off == `HFH_OFF_TX_WM)   tx_wm_r   <= i_wdata;
            if (wr_hit && off == `HFH_OFF_TX_MASK) tx_mask_r <= i_wdata;
            if (wr_hit && off == `HFH_OFF_TX_MISC)
                tx_misc_r <= i_wdata;
            else if (tx_wrt)
                tx_misc_r[`HFH_TX_MISC_EOM] <= 1'b0;
            // write one clears, new event wins
            rx_lat_r <= (rx_lat_r & ~((wr_hit && off == `HFH_OFF_RX_LAT)
                        ? i_wdata : 8'h00)) | rx_set;
            tx_lat_r <= (tx_lat_r & ~((wr_hit && off == `HFH_OFF_TX_LAT)
                        ? i_wdata : 8'h00)) | tx_set;
            // pending cleared by reading the status
            rx_pend_r <= (rx_pend_r & ((rd_hit && off == `HFH_OFF_RX_LAT)
                         ? 8'h00 : 8'hff)) | rx_set;
            tx_pend_r <= (tx_pend_r & ((rd_hit && off == `HFH_OFF_TX_LAT)
                         ? 8'h00 : 8'hff)) | tx_set;
        end
    end

    // interrupt output
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_interrupt_out_n <= 1'b1;
        end else begin
            o_interrupt_out_n <= !(|(rx_pend_r & rx_mask_r)
                                   || |(tx_pend_r & tx_mask_r));
        end
    end

    // read data, captured once so it holds through the cycle
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= 8'h00;
        end else if (rd_hit) begin
            case (off)
                `HFH_OFF_RX_MAP:   o_rdata <= rx_map_r;
                `HFH_OFF_RX_SUP:   o_rdata <= rx_sup_r;
                `HFH_OFF_RX_WM:    o_rdata <= rx_wm_r;
                `HFH_OFF_RX_LAT:   o_rdata <= rx_lat_r;
                `HFH_OFF_RX_MASK:  o_rdata <= rx_mask_r;
                `HFH_OFF_RX_LIVE:  o_rdata <= {6'h00, rx_hwm_nxt,
                                              rx_cnt_r != 0};
                `HFH_OFF_RX_AVAIL: o_rdata <= {rx_cont, avail};
                `HFH_OFF_RX_DATA:  o_rdata <= rx_mem[rx_rd_r];
                `HFH_OFF_TX_MISC:  o_rdata <= tx_misc_r;
                `HFH_OFF_TX_SUP:   o_rdata <= tx_sup_r;
                `HFH_OFF_TX_MAP:   o_rdata <= tx_map_r;
                `HFH_OFF_TX_WM:    o_rdata <= tx_wm_r;
                `HFH_OFF_TX_LAT:   o_rdata <= tx_lat_r;
                `HFH_OFF_TX_MASK:  o_rdata <= tx_mask_r;
                `HFH_OFF_TX_LIVE:  o_rdata <= {6'h00, tx_lwm_nxt,
                                              tx_cnt_r == 0};
                `HFH_OFF_TX_AVAIL: o_rdata <= {1'b0, FULL - tx_cnt_r};
                default:           o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end

    // receive fifo, 64 bytes with end marks
    always @(posedge i_clk) begin
        if (rx_put)
            rx_mem[rx_wr_r] <= rx_pbyte_r;
    end
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rx_rd_r   <= {FIFO_AW{1'b0}};
            rx_wr_r   <= {FIFO_AW{1'b0}};
            rx_cnt_r  <= {(FIFO_AW+1){1'b0}};
            rx_mark_r <= {DEPTH{1'b0}};
            rx_drop_r <= 1'b0;
        end else if (rx_over) begin
            rx_rd_r   <= {FIFO_AW{1'b0}};
            rx_wr_r   <= {FIFO_AW{1'b0}};
            rx_cnt_r  <= {(FIFO_AW+1){1'b0}};
            rx_mark_r <= {DEPTH{1'b0}};
            rx_drop_r <= 1'b1;
        end else begin
            if (rx_start_r)
                rx_drop_r <= 1'b0;
            if (rx_put) begin
                rx_wr_r            <= rx_wr_r + 1'b1;
                rx_mark_r[rx_wr_r] <= 1'b0;
            end
            if (rx_end_r && !rx_drop_r && rx_cnt_r != 0)
                rx_mark_r[rx_wr_r - 1'b1] <= 1'b1;
            if (rx_pop)
                rx_rd_r <= rx_rd_r + 1'b1;
            if (rx_put && !rx_pop)
                rx_cnt_r <= rx_cnt_r + 1'b1;
            else if (rx_pop && !rx_put)
                rx_cnt_r <= rx_cnt_r - 1'b1;
        end
    end

    // receive engine: destuff, flags, aborts, crc, alignment
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rx_ones_r  <= 3'd0;
            rx_bits_r  <= 3'd0;
            rx_sh_r    <= 8'h00;
            rx_h0_r    <= 8'h00;
            rx_h1_r    <= 8'h00;
            rx_held_r  <= 2'd0;
            rx_infr_r  <= 1'b0;
            rx_any_r   <= 1'b0;
            rx_crc_r   <= `HFH_CRC_INIT;
            rx_push_r  <= 1'b0;
            rx_pbyte_r <= 8'h00;
            rx_end_r   <= 1'b0;
            rx_start_r <= 1'b0;
            rx_ok_r    <= 1'b0;
            rx_bad_r   <= 1'b0;
            rx_abt_r   <= 1'b0;
        end else begin
            rx_push_r  <= 1'b0;
            rx_end_r   <= 1'b0;
            rx_start_r <= 1'b0;
            rx_ok_r    <= 1'b0;
            rx_bad_r   <= 1'b0;
            rx_abt_r   <= 1'b0;
            if (rx_take && i_rx_bit && rx_ones_r == 3'd6) begin
                // seventh one: abort
                rx_ones_r <= 3'd7;
                rx_infr_r <= 1'b0;
                rx_abt_r  <= rx_infr_r && rx_any_r;
                rx_end_r  <= rx_infr_r && rx_any_r;
            end else if (rx_take && i_rx_bit) begin
                if (rx_ones_r != 3'd7)
                    rx_ones_r <= rx_ones_r + 1'b1;
                rx_sh_r   <= {1'b1, rx_sh_r[7:1]};
                rx_bits_r <= rx_bits_r + 1'b1;
            end else if (rx_take && rx_ones_r == 3'd6) begin
                // flag closes one frame and opens the next
                if (rx_infr_r && rx_any_r) begin
                    rx_end_r <= 1'b1;
                    if (rx_bits_r == 3'd7 && rx_held_r == 2'd2
                        && rx_crc_r == `HFH_CRC_GOOD)
                        rx_ok_r <= 1'b1;
                    else
                        rx_bad_r <= 1'b1;
                end
                rx_ones_r  <= 3'd0;
                rx_bits_r  <= 3'd0;
                rx_held_r  <= 2'd0;
                rx_any_r   <= 1'b0;
                rx_infr_r  <= 1'b1;
                rx_start_r <= 1'b1;
                rx_crc_r   <= `HFH_CRC_INIT;
            end else if (rx_take && rx_ones_r == 3'd5) begin
                rx_ones_r <= 3'd0;              // stuffed zero dropped
            end else if (rx_take) begin
                rx_ones_r <= 3'd0;
                rx_sh_r   <= {1'b0, rx_sh_r[7:1]};
                rx_bits_r <= rx_bits_r + 1'b1;
            end
            // byte complete: hold two bytes back so fcs never reaches fifo
            if (rx_take && rx_ones_r != 3'd5 && rx_ones_r != 3'd6
                && rx_bits_r == 3'd7 && rx_infr_r) begin
                rx_crc_r <= crc_byte(rx_crc_r, {i_rx_bit, rx_sh_r[7:1]});
                rx_h0_r  <= {i_rx_bit, rx_sh_r[7:1]};
                rx_h1_r  <= rx_h0_r;
                if (rx_held_r == 2'd2) begin
                    rx_push_r  <= 1'b1;
                    rx_pbyte_r <= rx_h1_r;
                    rx_any_r   <= 1'b1;
                end else begin
                    rx_held_r <= rx_held_r + 1'b1;
                end
            end
        end
    end

    // transmit fifo, 64 bytes with end mark
    always @(posedge i_clk) begin
        if (tx_push)
            tx_mem[tx_wr_r] <= {tx_misc_r[`HFH_TX_MISC_EOM], i_wdata};
    end
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            tx_rd_r  <= {FIFO_AW{1'b0}};
            tx_wr_r  <= {FIFO_AW{1'b0}};
            tx_cnt_r <= {(FIFO_AW+1){1'b0}};
        end else begin
            if (tx_push)
                tx_wr_r <= tx_wr_r + 1'b1;
            if (tx_pop)
                tx_rd_r <= tx_rd_r + 1'b1;
            if (tx_push && !tx_pop)
                tx_cnt_r <= tx_cnt_r + 1'b1;
            else if (tx_pop && !tx_push)
                tx_cnt_r <= tx_cnt_r - 1'b1;
        end
    end

    // transmit engine: flags, stuffing, fcs, abort on underrun
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            tx_st_r        <= T_IDLE;
            tx_sh_r        <= {8'h00, `HFH_FLAG};
            tx_left_r      <= 5'd8;
            tx_ones_r      <= 3'd0;
            tx_crc_r       <= `HFH_CRC_INIT;
            tx_last_r      <= 1'b0;
            o_tx_bit       <= 1'b1;
            o_tx_bit_valid <= 1'b0;
        end else begin
            o_tx_bit_valid <= tx_take;
            if (tx_take)
                o_tx_bit <= tx_nxt;
            if (tx_take && tx_stuff) begin
                tx_ones_r <= 3'd0;
            end else if (tx_take) begin
                tx_ones_r <= tx_sh_r[0] ? tx_ones_r + 1'b1 : 3'd0;
                tx_sh_r   <= {1'b0, tx_sh_r[15:1]};
                tx_left_r <= tx_left_r - 1'b1;
                if (tx_left_r == 5'd1) begin
                    if (tx_pop) begin
                        tx_sh_r   <= {8'h00, tx_head[7:0]};
                        tx_left_r <= 5'd8;
                        tx_last_r <= tx_head[8];
                        tx_crc_r  <= crc_byte(tx_st_r == T_IDLE
                                     ? `HFH_CRC_INIT : tx_crc_r,
                                     tx_head[7:0]);
                        tx_st_r   <= T_DATA;
                        if (tx_st_r == T_IDLE)
                            tx_ones_r <= 3'd0;
                    end else if (tx_eop) begin
                        tx_sh_r   <= ~tx_crc_r;
                        tx_left_r <= 5'd16;
                        tx_st_r   <= T_FCS;
                    end else if (tx_udr) begin
                        tx_sh_r   <= {8'h00, `HFH_ABORT};
                        tx_left_r <= 5'd8;
                        tx_st_r   <= T_ABRT;
                    end else begin
                        tx_sh_r   <= {8'h00, `HFH_FLAG};
                        tx_left_r <= 5'd8;
                        tx_ones_r <= 3'd0;
                        tx_st_r   <= T_IDLE;
                    end
                end
            end
        end
    end

endmodule // hfh_hdlc_port
`default_nettype wire

// >>> hfh_hdlc_port_end.v
// spare file holder intentionally empty of logic
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// >>> hfh_line_model.sv
// line-side framer model for the hdlc port
`timescale 1ns/10ps
`default_nettype none
module hfh_line_model (
    input  wire logic       i_clk,
    output var  logic       o_rx_bit_en = 1'b0,
    output var  logic       o_rx_bit = 1'b0,
    output var  logic [2:0] o_bitpos = 3'h0,
    output var  logic       o_tx_bit_req = 1'b0
);
    task automatic send(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            @(posedge i_clk);
            o_rx_bit_en <= 1'b1;
            o_rx_bit <= b[i];
            o_bitpos <= i[2:0];
            @(posedge i_clk);
            o_rx_bit_en <= 1'b0;
            o_rx_bit <= ~b[i];
        end
    endtask
    task automatic pull(input int n);
        repeat (n) begin
            @(posedge i_clk);
            o_tx_bit_req <= 1'b1;
            @(posedge i_clk);
            o_tx_bit_req <= 1'b0;
        end
    endtask
endmodule // hfh_line_model
`default_nettype wire

// >>> hfh_port_properties.sv
// pin-level checks for the hdlc port
`timescale 1ns/10ps
`default_nettype none
module hfh_port_properties (
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic [12:0] i_addr,
    input wire logic        i_rd,
    input wire logic [7:0]  o_rdata,
    input wire logic        i_tx_bit_req,
    input wire logic        o_tx_bit,
    input wire logic        o_tx_bit_valid
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_rd(a);
        i_rd && i_addr == a;
    endsequence
    chk_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00)
        else $error("rdata not idle");
    chk_port_dec: assert property (i_rd && |i_addr[12:9] |=>
        o_rdata == 8'h00) else $error("other port answered");
    chk_avail_max: assert property (s_rd(13'h0b5) |=>
        o_rdata[6:0] <= 7'h40) else $error("rx count range");
    chk_cont_count: assert property (s_rd(13'h0b5) |=>
        !o_rdata[7] || o_rdata[6:0] != 7'h00) else $error("cont flag");
    chk_txfree_max: assert property (s_rd(13'h1b3) |=>
        o_rdata <= 8'h40) else $error("tx free range");
    chk_live_wm: assert property (s_rd(13'h0b4) |=>
        !o_rdata[1] || o_rdata[0]) else $error("rx live flags");
    chk_txv_cause: assert property (o_tx_bit_valid |->
        $past(i_tx_bit_req)) else $error("tx valid uncaused");
    chk_txbit_hold: assert property (!i_tx_bit_req |=>
        $stable(o_tx_bit)) else $error("tx bit moved");
endmodule // hfh_port_properties
bind hfh_hdlc_port hfh_port_properties u_chk (.i_clk(i_clk),
    .i_rst(i_rst), .i_addr(i_addr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_tx_bit_req(i_tx_bit_req), .o_tx_bit(o_tx_bit),
    .o_tx_bit_valid(o_tx_bit_valid));
`default_nettype wire

// >>> tb_hfh_hdlc_port.sv
// self-checking bench for the hdlc port
`timescale 1ns/10ps
`default_nettype none
module tb_hfh_hdlc_port;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic [12:0] i_addr = 13'h0;
    logic [7:0]  i_wdata = 8'h00;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic [7:0]  last = 8'h00;
    logic [4:0]  slot = 5'h00;
    wire  [7:0]  o_rdata;
    wire  [2:0]  pos;
    wire         rx_en, rx_bit, tx_req, tx_bit, tx_vld, irq_n;
    int          bad_count = 0;
    int          cmp_count = 0;
    int          n;
    always #4 i_clk = ~i_clk;
    hfh_line_model u_line (.i_clk(i_clk), .o_rx_bit_en(rx_en),
        .o_rx_bit(rx_bit), .o_bitpos(pos), .o_tx_bit_req(tx_req));
    hfh_hdlc_port DUT (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_rx_bit_en(rx_en), .i_rx_bit(rx_bit), .i_rx_slot(slot),
        .i_rx_bitpos(pos), .i_rx_fdl(1'b0), .i_rx_sa(1'b0),
        .i_tx_bit_req(tx_req), .i_tx_slot(slot), .i_tx_bitpos(pos),
        .i_tx_fdl(1'b0), .i_tx_sa(1'b0), .o_tx_bit(tx_bit),
        .o_tx_bit_valid(tx_vld), .o_interrupt_out_n(irq_n));
    task automatic chk(input logic [7:0] got, e, m);
        cmp_count++;
        if ((got & m) !== (e & m)) begin
            bad_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, e);
        end
    endtask
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        @(posedge i_clk);
        {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [12:0] a, input logic [7:0] e, m);
        @(posedge i_clk);
        {i_rd, i_addr} <= {1'b1, a};
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 last = o_rdata;
        chk(last, e, m);
    endtask
    task automatic frame3;
        u_line.send(8'h7e);
        repeat (3) u_line.send(8'h11);
    endtask
    task automatic results;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge i_clk);
        i_rst <= 1'b0;
        rd(13'h1b3, 8'h40, 8'hff);
        rd(13'h0b5, 8'h00, 8'hff);
        rd(13'h0ff, 8'h00, 8'hff);
        wr(13'h087, 8'h02);
        rd(13'h087, 8'h02, 8'hff);
        rd(13'h287, 8'h00, 8'hff);
        $display("test regs done");
        wr(13'h187, 8'h05);
        rd(13'h1b1, 8'h03, 8'hff);
        for (n = 0; n < 6; n++) wr(13'h1b4, 8'h41);
        rd(13'h1b3, 8'h3a, 8'hff);
        rd(13'h1b1, 8'h00, 8'hff);
        $display("test tx level done");
        u_line.send(8'h7e);
        for (n = 1; n < 7; n++) u_line.send(8'h11 * n[7:0]);
        rd(13'h0b5, 8'h84, 8'hff);
        rd(13'h0b4, 8'h03, 8'hff);
        for (n = 1; n < 5; n++) rd(13'h0b6, 8'h11 * n[7:0], 8'hff);
        rd(13'h0b5, 8'h00, 8'hff);
        $display("test rx count done");
        wr(13'h0a4, 8'h20);
        u_line.send(8'h7e);
        repeat (70) u_line.send(8'h00);
        rd(13'h0b5, 8'h00, 8'hff);
        chk({7'h0, irq_n}, 8'h00, 8'h01);
        rd(13'h094, 8'h20, 8'h20);
        repeat (2) @(posedge i_clk);
        chk({7'h0, irq_n}, 8'h01, 8'h01);
        wr(13'h094, 8'h00);
        rd(13'h094, 8'h20, 8'h20);
        wr(13'h094, 8'h20);
        rd(13'h094, 8'h00, 8'h20);
        $display("test overrun done");
        wr(13'h010, 8'h03);
        frame3;
        rd(13'h0b5, 8'h00, 8'hff);
        slot <= 5'h03;
        wr(13'h011, 8'hff);
        frame3;
        rd(13'h0b5, 8'h00, 8'hff);
        wr(13'h011, 8'h00);
        frame3;
        rd(13'h0b5, 8'h81, 8'hff);
        slot <= 5'h00;
        $display("test slot map done");
        wr(13'h191, 8'hff);
        rd(13'h191, 8'h00, 8'h02);
        wr(13'h1a1, 8'h02);
        chk({7'h0, irq_n}, 8'h01, 8'h01);
        for (n = 0; n < 50 && last !== 8'h40; n++) begin
            u_line.pull(20);
            rd(13'h1b3, 8'h00, 8'h80);
        end
        if (last !== 8'h40) begin
            bad_count++;
            $display("MISMATCH t=%0t tx drain timeout", $time);
        end
        chk({7'h0, irq_n}, 8'h00, 8'h01);
        rd(13'h1b3, 8'h40, 8'hff);
        rd(13'h191, 8'h02, 8'h02);
        $display("test tx drain done");
        results;
    end
endmodule // tb_hfh_hdlc_port
`default_nettype wire
